// ===== common/rdcc_consts.vh
// Constants shared by the remap drain and command control block
`ifndef RDCC_CONSTS_VH
`define RDCC_CONSTS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define RDCC_IDX_W 4
`define RDCC_SLOTS 16
`define RDCC_CNT_W 5

// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define RDCC_ST_W 3
`define RDCC_ST_IDLE 3'h0
`define RDCC_ST_FLUSH 3'h1
`define RDCC_ST_INV 3'h2
`define RDCC_ST_DRAIN 3'h3
`define RDCC_ST_DONE 3'h4

// ----------------------------------------
// Command codes
// ----------------------------------------
`define RDCC_CMD_W 3
`define RDCC_CMD_NONE 3'h0
`define RDCC_CMD_IR_EN 3'h1
`define RDCC_CMD_IR_DIS 3'h2
`define RDCC_CMD_IEC 3'h3
`define RDCC_CMD_CTX 3'h4
`define RDCC_CMD_IOTLB 3'h5
`define RDCC_CMD_TR_EN 3'h6
`define RDCC_CMD_WBF 3'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define RDCC_FLUSH_CYC 4'h4
`define RDCC_INV_CYC 4'h2

`endif

// ===== hw/rdcc_pend_table.v
// Table of non-committed interrupt requests, one slot per interrupt index
`include "rdcc_consts.vh"

module rdcc_pend_table
(
    input wire clk,
    input wire rst_n,
    input wire enq_valid,
    input wire [`RDCC_IDX_W-1:0] enq_index,
    input wire enq_compat,
    input wire ack_valid,
    input wire [`RDCC_IDX_W-1:0] ack_index,
    input wire [`RDCC_SLOTS-1:0] watch_mask,
    output reg [`RDCC_SLOTS-1:0] pend,
    output reg watched_busy
);

    // ----------------------------------------
    // Per-slot pending bits
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `RDCC_SLOTS; g = g + 1)
        begin : slot
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    pend[g] <= 1'b0;
                else if (enq_valid && !enq_compat && enq_index == g)
                    pend[g] <= 1'b1;
                else if (ack_valid && ack_index == g)
                    pend[g] <= 1'b0;
            end
        end
    endgenerate

    // Registered so the sequencer reads a settled view
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            watched_busy <= 1'b0;
        else
            watched_busy <= |(pend & watch_mask);
    end

endmodule

// ===== hw/rdcc_ctrl.v
// Drain sequencing and command serialization for a remapping unit
`include "rdcc_consts.vh"

// How it works
// - Drain all non-committed non-compat interrupts
// - Drain before setting intr remap status
// - Optional drain on remap disable
// - Queued IEC invalidation drains before wait completes
// - Global IEC drains all pending interrupts
// - Index IEC drains only named index
// - Drained only on processor complex acknowledge
// - Implicit write flush before invalidations
// - Newer parts report flush not required
// - No cross-unit serialization imposed
// - Translation status set after request drain
module rdcc_ctrl
#(
    parameter FLUSH_REQ = 1'b1,
    parameter DRAIN_ON_DISABLE = 1'b1
)
(
    input wire clk,
    input wire rst_n,
    input wire cmd_valid,
    input wire [`RDCC_CMD_W-1:0] cmd_code,
    input wire cmd_global,
    input wire [`RDCC_IDX_W-1:0] cmd_index,
    input wire cmd_queued,
    input wire intr_valid,
    input wire [`RDCC_IDX_W-1:0] intr_index,
    input wire intr_compat,
    input wire intr_ack,
    input wire [`RDCC_IDX_W-1:0] intr_ack_index,
    input wire req_drain_done,
    input wire wait_dsc_req,
    output reg cmd_pending,
    output reg intr_remap_enable_status,
    output reg translation_enable_status,
    output reg write_flush_required,
    output reg wbuf_flush_req,
    output reg req_drain_req,
    output reg wait_dsc_done,
    output reg [`RDCC_SLOTS-1:0] intr_pending
);

    reg [`RDCC_ST_W-1:0] state;
    reg [`RDCC_ST_W-1:0] next_state;
    reg [`RDCC_CMD_W-1:0] cur_cmd;
    reg [`RDCC_SLOTS-1:0] watch_mask;
    reg [3:0] timer;
    reg queued_drain_open;
    wire [`RDCC_SLOTS-1:0] pend;
    wire watched_busy;
    wire is_inv;
    wire needs_drain;
    wire [`RDCC_SLOTS-1:0] idx_mask;

    rdcc_pend_table u_table
    (
        .clk(clk),
        .rst_n(rst_n),
        .enq_valid(intr_valid),
        .enq_index(intr_index),
        .enq_compat(intr_compat),
        .ack_valid(intr_ack),
        .ack_index(intr_ack_index),
        .watch_mask(watch_mask),
        .pend(pend),
        .watched_busy(watched_busy)
    );

    assign is_inv = (cur_cmd == `RDCC_CMD_IEC) || (cur_cmd == `RDCC_CMD_CTX) || (cur_cmd == `RDCC_CMD_IOTLB);
    assign needs_drain = (cur_cmd == `RDCC_CMD_IEC) || (cur_cmd == `RDCC_CMD_IR_EN) ||
                         (cur_cmd == `RDCC_CMD_TR_EN) || (cur_cmd == `RDCC_CMD_IR_DIS && DRAIN_ON_DISABLE);
    assign idx_mask = {{(`RDCC_SLOTS-1){1'b0}}, 1'b1} << cmd_index;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @*
    begin
        next_state = state;
        case (state)
            `RDCC_ST_IDLE:
                if (cmd_valid && cmd_code != `RDCC_CMD_NONE)
                    next_state = `RDCC_ST_FLUSH;
            `RDCC_ST_FLUSH:
                if (timer == 4'h0)
                    next_state = `RDCC_ST_INV;
            `RDCC_ST_INV:
                if (timer == 4'h0)
                    next_state = needs_drain ? `RDCC_ST_DRAIN : `RDCC_ST_DONE;
            `RDCC_ST_DRAIN:
                if (cur_cmd == `RDCC_CMD_TR_EN ? req_drain_done : !watched_busy)
                    next_state = `RDCC_ST_DONE;
            default:
                next_state = `RDCC_ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= `RDCC_ST_IDLE;
            cur_cmd <= `RDCC_CMD_NONE;
            watch_mask <= {`RDCC_SLOTS{1'b0}};
            timer <= 4'h0;
            cmd_pending <= 1'b0;
            intr_remap_enable_status <= 1'b0;
            translation_enable_status <= 1'b0;
            write_flush_required <= 1'b0;
            wbuf_flush_req <= 1'b0;
            req_drain_req <= 1'b0;
            queued_drain_open <= 1'b0;
            wait_dsc_done <= 1'b0;
            intr_pending <= {`RDCC_SLOTS{1'b0}};
        end
        else
        begin
            state <= next_state;
            write_flush_required <= FLUSH_REQ;
            intr_pending <= pend;
            wait_dsc_done <= 1'b0;
            // Queued waits stall until the preceding IEC drain is over
            if (wait_dsc_req && !queued_drain_open && !wait_dsc_done)
                wait_dsc_done <= 1'b1;
            case (state)
                `RDCC_ST_IDLE:
                    // A request while busy is ignored; this unit waits on no other unit
                    if (cmd_valid && cmd_code != `RDCC_CMD_NONE)
                    begin
                        cur_cmd <= cmd_code;
                        cmd_pending <= 1'b1;
                        // Global drains every slot, selective only the named one
                        watch_mask <= (cmd_code != `RDCC_CMD_IEC || cmd_global) ?
                                      {`RDCC_SLOTS{1'b1}} : idx_mask;
                        queued_drain_open <= cmd_queued && cmd_code == `RDCC_CMD_IEC;
                        if (cmd_code == `RDCC_CMD_IR_DIS)
                            intr_remap_enable_status <= 1'b0;
                        if (FLUSH_REQ && (cmd_code == `RDCC_CMD_IEC || cmd_code == `RDCC_CMD_CTX ||
                            cmd_code == `RDCC_CMD_IOTLB || cmd_code == `RDCC_CMD_WBF))
                        begin
                            wbuf_flush_req <= 1'b1;
                            timer <= `RDCC_FLUSH_CYC;
                        end
                        else
                            timer <= 4'h0;
                    end
                `RDCC_ST_FLUSH:
                    if (timer == 4'h0)
                    begin
                        wbuf_flush_req <= 1'b0;
                        timer <= is_inv ? `RDCC_INV_CYC : 4'h0;
                    end
                    else
                        timer <= timer - 4'h1;
                `RDCC_ST_INV:
                    if (timer == 4'h0)
                        req_drain_req <= (cur_cmd == `RDCC_CMD_TR_EN);
                    else
                        timer <= timer - 4'h1;
                `RDCC_ST_DRAIN:
                    // Status rises only once the drain is acknowledged
                    if (next_state == `RDCC_ST_DONE)
                    begin
                        req_drain_req <= 1'b0;
                        if (cur_cmd == `RDCC_CMD_IR_EN)
                            intr_remap_enable_status <= 1'b1;
                        if (cur_cmd == `RDCC_CMD_TR_EN)
                            translation_enable_status <= 1'b1;
                    end
                default:
                begin
                    cmd_pending <= 1'b0;
                    queued_drain_open <= 1'b0;
                end
            endcase
        end
    end

endmodule

// ===== verification/rdcc_ctrl_props.sv
// Checker of drain and command sequencing at the control ports
module rdcc_ctrl_props
#(
    parameter FLUSH_REQ = 1'b1
)
(
    input wire clk,
    input wire rst_n,
    input wire cmd_valid,
    input wire [2:0] cmd_code,
    input wire cmd_global,
    input wire cmd_queued,
    input wire cmd_pending,
    input wire intr_remap_enable_status,
    input wire translation_enable_status,
    input wire write_flush_required,
    input wire wbuf_flush_req,
    input wire req_drain_req,
    input wire wait_dsc_done,
    input wire [15:0] intr_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire take = cmd_valid && !cmd_pending && cmd_code != 3'h0;
    wire inv = cmd_code == 3'h3 || cmd_code == 3'h4 || cmd_code == 3'h5;
    reg qiec;
    reg glob;
    // Kind of the command in flight, kept until the next one is taken
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            {qiec, glob} <= 2'b00;
        else if (take)
            {qiec, glob} <= {cmd_code == 3'h3 && cmd_queued, cmd_code == 3'h1 || (cmd_code == 3'h3 && cmd_global)};
    end
    sequence flush_run;
        wbuf_flush_req [*5] ##1 !wbuf_flush_req;
    endsequence
    flush_first_a: assert property (take && inv && FLUSH_REQ |=> flush_run) else $error("flush missing");
    flush_idle_a: assert property (!cmd_pending |-> !wbuf_flush_req) else $error("stray flush");
    pend_take_a: assert property (take |=> cmd_pending) else $error("pending not raised");
    ies_drained_a: assert property ($rose(intr_remap_enable_status) |-> $past(intr_pending) == 16'h0) else $error("ies early");
    tes_drained_a: assert property ($rose(translation_enable_status) |-> $past(req_drain_req)) else $error("tes early");
    wait_held_a: assert property (wait_dsc_done |-> !(qiec && cmd_pending)) else $error("wait done early");
    ies_off_a: assert property (take && cmd_code == 3'h2 |=> !intr_remap_enable_status) else $error("ies kept");
    cap_value_a: assert property ($past(rst_n) |-> write_flush_required == FLUSH_REQ) else $error("cap wrong");
    drain_all_a: assert property ($fell(cmd_pending) && glob |-> intr_pending == 16'h0) else $error("slot left");
endmodule

// ===== verification/rdcc_partner.sv
// Local interrupt controller and request drain model at the far side
module rdcc_partner
(
    input wire logic clk,
    input wire logic [15:0] intr_pending,
    input wire logic req_drain_req,
    input wire logic [3:0] gap,
    output logic intr_ack,
    output logic [3:0] intr_ack_index,
    output logic req_drain_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    initial {intr_ack, intr_ack_index, req_drain_done} = 6'h0;
    // A gap of f stalls; the index line toggles while no ack is given
    always @(negedge clk)
    begin
        intr_ack <= 1'b0;
        intr_ack_index <= ~intr_ack_index;
        req_drain_done <= req_drain_req && (req_drain_done || (n >= gap && gap != 4'hf));
        n <= (n >= gap) ? 0 : n + 1;
        if (n >= gap && gap != 4'hf)
            for (int i = 15; i >= 0; i--)
                if (intr_pending[i] === 1'b1)
                    {intr_ack, intr_ack_index} <= {1'b1, 4'(i)};
    end
endmodule

// ===== verification/rdcc_ctrl_bench.sv
// Self-checking bench for the drain and command control block
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module rdcc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk = 0, rst_n = 0, cmd_valid = 0, cmd_global = 0, cmd_queued = 0;
    reg intr_valid = 0, intr_compat = 0, wait_dsc_req = 0, ies_m = 0, tes_m = 0;
    reg [2:0] cmd_code = 0;
    reg [3:0] cmd_index = 0, intr_index = 0, gap = 4'hf;
    reg [15:0] mdl = 0, mdl_q = 0;
    wire cmd_pending, intr_remap_enable_status, translation_enable_status, write_flush_required;
    wire wbuf_flush_req, req_drain_req, wait_dsc_done, intr_ack, req_drain_done;
    wire [3:0] intr_ack_index;
    wire [15:0] intr_pending;
    int n_fail = 0, samples_checked = 0, cyc = 0, fl, dr, seen, i;
    rdcc_ctrl rdcc_ctrl_i(.clk, .rst_n, .cmd_valid, .cmd_code, .cmd_global, .cmd_index, .cmd_queued,
        .intr_valid, .intr_index, .intr_compat, .intr_ack, .intr_ack_index, .req_drain_done, .wait_dsc_req,
        .cmd_pending, .intr_remap_enable_status, .translation_enable_status, .write_flush_required,
        .wbuf_flush_req, .req_drain_req, .wait_dsc_done, .intr_pending);
    rdcc_partner rdcc_partner_i(.clk, .intr_pending, .req_drain_req, .gap, .intr_ack, .intr_ack_index,
        .req_drain_done);
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        seen += wait_dsc_done;
        // Slot model kept one edge behind, as the pending output is; a new request beats an ack
        if (!rst_n)
            {mdl, mdl_q} = 0;
        else
        begin
            mdl_q = mdl;
            if (intr_ack)
                mdl[intr_ack_index] = 1'b0;
            if (intr_valid && !intr_compat)
                mdl[intr_index] = 1'b1;
        end
        if (cyc == 20000)
        begin
            n_fail++;
            test_done;
        end
    end
    task test_done;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task inj(input c);
        @(negedge clk);
        {intr_valid, intr_compat, intr_index} = {1'b1, c, 4'($urandom)};
        @(negedge clk);
        intr_valid = 0;
    endtask
    // A dup request is a disable held on while busy, which must be ignored
    task cmd(input [2:0] c, input g, input q, input dup, input [3:0] x);
        int k;
        @(negedge clk);
        {cmd_valid, cmd_code, cmd_global, cmd_queued, cmd_index} = {1'b1, c, g, q, x};
        fl = 0;
        dr = 0;
        for (k = 0; k < 400 && (k < 2 || cmd_pending === 1'b1); k++)
        begin
            @(negedge clk);
            cmd_valid = dup && k == 0;
            cmd_code = dup ? 3'h2 : c;
            fl += wbuf_flush_req;
            dr += req_drain_req;
        end
        `CHK("pending", 1'b0, cmd_pending)
        if (c == 3'h3 || c == 3'h4 || c == 3'h5)
            `CHK("flush", 5, fl)
        if (c == 3'h3 && !g)
            `CHK("slot", 1'b0, intr_pending[x])
        if (c == 3'h1 || c == 3'h2 || (c == 3'h3 && g))
            `CHK("drained", 16'h0, intr_pending)
        if (c == 3'h6)
            `CHK("drain req", 1'b1, dr > 0)
        ies_m = (c == 3'h1) ? 1'b1 : (c == 3'h2) ? 1'b0 : ies_m;
        tes_m = tes_m || c == 3'h6;
        `CHK("pending slots", mdl_q, intr_pending)
        `CHK("drain req idle", 1'b0, req_drain_req)
        `CHK("ies", ies_m, intr_remap_enable_status)
        `CHK("tes", tes_m, translation_enable_status)
    endtask
    initial
    begin
        void'($urandom(89657));
        repeat (5) @(negedge clk);
        rst_n = 1;
        repeat (2) @(negedge clk);
        `CHK("flush cap", 1'b1, write_flush_required)
        gap = 2;
        cmd(3, 1, 0, 0, 0);
        gap = 4'hf;
        inj(0);
        repeat (6) inj($urandom % 2);
        repeat (2) @(negedge clk);
        `CHK("queued", mdl_q, intr_pending)
        fork
            cmd(1, 0, 0, 1, 0);
            begin
                repeat (30) @(negedge clk);
                `CHK("early ies", 1'b0, intr_remap_enable_status)
                gap = 2;
            end
        join
        gap = 4'hf;
        repeat (3) inj(0);
        seen = 0;
        fork
            cmd(3, 0, 1, 0, intr_index);
            begin
                repeat (3) @(negedge clk);
                wait_dsc_req = 1;
                repeat (30) @(negedge clk);
                `CHK("early wait", 0, seen)
                gap = 3;
            end
        join
        repeat (5) @(negedge clk);
        wait_dsc_req = 0;
        `CHK("wait done", 1'b1, seen > 0)
        // Invalidations precede the enables they guard; tables and mode never change while live
        for (i = 0; i < 7; i++)
        begin
            gap = 2 + $urandom % 12;
            inj(0);
            cmd(3'((i + 2) % 7 + 1), 1, 0, 0, 0);
        end
        rst_n = 0;
        {ies_m, tes_m} = 0;
        @(negedge clk);
        `CHK("reset state", 3'h0, {cmd_pending, intr_remap_enable_status, translation_enable_status})
        rst_n = 1;
        repeat (2) @(negedge clk);
        cmd(3, 1, 0, 0, 0);
        inj(0);
        cmd(1, 0, 0, 0, 0);
        test_done;
    end
endmodule
bind rdcc_ctrl rdcc_ctrl_props #(.FLUSH_REQ(FLUSH_REQ)) rdcc_ctrl_props_i(.clk, .rst_n, .cmd_valid, .cmd_code,
    .cmd_global, .cmd_queued, .cmd_pending, .intr_remap_enable_status, .translation_enable_status,
    .write_flush_required, .wbuf_flush_req, .req_drain_req, .wait_dsc_done, .intr_pending);
